// ==== logic/csc_cfg.svh ====
// Constants of the compressor supervisory controller: offsets, fields, resets, timings.
// Assumes inclusion by bare name from the package, which the design file imports.
`ifndef CSC_CFG_SVH
`define CSC_CFG_SVH
// System clock rate in hertz.
`define CSC_CLK_HZ 250000000
// Register byte offsets on the Avalon-MM slave.
`define CSC_OFS_CMD 4'h0
`define CSC_OFS_STATUS 4'h4
`define CSC_OFS_POINTS 4'h8
// Command register fields (write one to pulse).
`define CSC_CMD_ON_BIT 0
`define CSC_CMD_OFF_BIT 1
// Reset values.
`define CSC_RST_WAIT 1'b1
`define CSC_RST_LINE 4'h0
// Display line count and the line numbers that matter to the logic.
`define CSC_NUM_LINES 4'hc
`define CSC_LINE_ELAPSED 4'h0
`define CSC_LINE_CH_RUN 4'hb
// Trip points.
`define CSC_HE_TEMP_MAX_C 8'h5d
`define CSC_WATER_TEMP_MAX_C 8'h23
`define CSC_FLOW_TEMP_MAX_C 8'h2e
`define CSC_RET_PRESS_MIN_PSIG 8'h0f
// Point classes: bit i is display line i+1.
`define CSC_SD_MASK 8'hb9
`define CSC_AL_MASK 8'h06
// Times in their own units, then derived counts of one-second ticks.
`define CSC_TICK_S 1
`define CSC_CH_LIMIT_MIN 30
`define CSC_RETRY_MIN 20
`define CSC_RST_IGNORE_MIN 19
`define CSC_DISP_TIMEOUT_S 30
`define CSC_RESTART_DLY_S 5
`define CSC_RETRY_MAX 3'h5
`define CSC_CH_LIMIT_T (`CSC_CH_LIMIT_MIN * 60 / `CSC_TICK_S)
`define CSC_RETRY_T (`CSC_RETRY_MIN * 60 / `CSC_TICK_S)
`define CSC_RST_IGNORE_T (`CSC_RST_IGNORE_MIN * 60 / `CSC_TICK_S)
`define CSC_DISP_TIMEOUT_T (`CSC_DISP_TIMEOUT_S / `CSC_TICK_S)
`define CSC_RESTART_DLY_T (`CSC_RESTART_DLY_S / `CSC_TICK_S)
// Clock cycles in one tick.
`define CSC_TICK_CYCLES (`CSC_CLK_HZ * `CSC_TICK_S)
`endif

// ==== logic/csc_ctrl.sv ====
// Supervisory controller for a cryogenic compressor: run control, restarts, faults, display.
// Assumes all inputs are synchronous to clk and the configuration strap is stable at reset release.
//
// What this block does
// - Panel ON starts, OFF stops both motors.
// - Mode two ignores panel and serial commands.
// - Remote run line starts and stops both.
// - Serial ON and OFF start and stop both.
// - Cold head alone while off; 30 minutes.
// - Power-up decides whether last stop was outage.
// - Outage restarts after delay; others do not.
// - Helium overheat retries five times, 20 minutes apart.
// - Reset or outage clears error and retries.
// - Mode two ignores remote reset first 19 minutes.
// - Up and down scroll lines with wrap.
// - Thirty idle seconds return to top line: elapsed time, or newest fault line.
// - New fault shows ERR and goes top.
// - Later faults take top; others stay visible.
// - Disconnected sensor shows FAIL.
// - Helium above 93 C is shutdown.
// - Water above 35 C is alarm only.
// - Return pressure below 15 psig is shutdown.
// - Cable and switch mismatch is shutdown.
// - Shutdown stops both motors and reports.
// - Local clearing only in mode one.
// - Remote pulse, both arrows, power cycle clear.
// - Mode one remote line takes priority.
`timescale 1ns/1ns
`default_nettype none
module csc_ctrl
  import csc_pkg::*;
#(
  parameter int TICK_CYCLES = `CSC_TICK_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Avalon-MM slave.
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Front panel buttons, high while pressed.
  input wire logic btn_on,
  input wire logic btn_off,
  input wire logic btn_up,
  input wire logic btn_down,
  // Configuration strap and power-up history.
  input wire logic cfg_mode2,
  input wire logic last_stop_outage,
  // Remote diagnostic connector inputs.
  input wire logic remote_run,
  input wire logic remote_reset,
  input wire logic cable_mode2,
  // Monitored points.
  input wire logic [7:0] he_temp_c,
  input wire logic [7:0] water_temp_c,
  input wire logic [7:0] flow_temp_c,
  input wire logic [7:0] ret_press_psig,
  input wire logic motor_trip,
  input wire logic phase_fault,
  input wire logic [7:0] sensor_open,
  // Motor drives.
  output logic comp_motor,
  output logic cold_head,
  // Remote connector status outputs.
  output logic [7:0] point_err,
  output logic shutdown_out,
  output logic alarm_out,
  // Display.
  output logic [3:0] disp_line,
  output logic [15:0] disp_status
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Index of the highest set bit of a point vector, as a display line.
  function automatic logic [3:0] csc_top_of(input logic [7:0] v);
    logic [3:0] r;
    r = `CSC_LINE_ELAPSED;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) begin
        r = 4'(i + 1);
      end
    end
    return r;
  endfunction

  // One display step with wrap; the cold head line exists only while stopped.
  function automatic logic [3:0] csc_step(input logic [3:0] l, input logic up, input logic off);
    logic [3:0] last;
    last = off ? `CSC_LINE_CH_RUN : 4'(`CSC_LINE_CH_RUN - 4'h1);
    if (up) begin
      csc_step = (l == `CSC_LINE_ELAPSED) ? last : 4'(l - 4'h1);
    end else begin
      csc_step = (l >= last) ? `CSC_LINE_ELAPSED : 4'(l + 4'h1);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State.

  csc_state_t st_ff;   // Registered state.
  csc_state_t nxt_st;  // Next state.

  // Live fault detection, one bit per point, in display-line order.
  logic [7:0] fault;
  assign fault = {
    cable_mode2 != st_ff.mode2,
    1'b0,                                        // Oil level point is unused.
    ret_press_psig < `CSC_RET_PRESS_MIN_PSIG,
    phase_fault,
    motor_trip,
    flow_temp_c > `CSC_FLOW_TEMP_MAX_C,
    water_temp_c > `CSC_WATER_TEMP_MAX_C,
    he_temp_c > `CSC_HE_TEMP_MAX_C
  };

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // All behaviour lives here; the flip-flop bank below only registers it.
  always_comb begin
    logic tick;
    logic e_on, e_off, e_up, e_down, e_rrun, e_rrst, f_rrun;
    logic ser_on, ser_off, clr, off_now;
    logic [7:0] err, newerr, sd_now;
    logic [31:0] sts;
    tick = 1'b0;
    e_on = 1'b0;
    e_off = 1'b0;
    e_up = 1'b0;
    e_down = 1'b0;
    e_rrun = 1'b0;
    e_rrst = 1'b0;
    f_rrun = 1'b0;
    ser_on = 1'b0;
    ser_off = 1'b0;
    clr = 1'b0;
    off_now = 1'b0;
    err = 8'h00;
    newerr = 8'h00;
    sd_now = 8'h00;
    sts = 32'h0;
    nxt_st = st_ff;

    // The first cycle after reset captures the strap and the outage history.
    if (!st_ff.init) begin
      nxt_st.init = 1'b1;
      nxt_st.mode2 = cfg_mode2;
      nxt_st.restart_pend = last_stop_outage;
      nxt_st.restart_sec = 8'h00;
    end

    // Free-running prescaler: every slow interval counts its ticks.
    tick = (st_ff.pre == 32'(TICK_CYCLES - 1));
    nxt_st.pre = tick ? 32'h0 : 32'(st_ff.pre + 32'h1);

    // Rising and falling edges of the level inputs.
    e_on = btn_on & ~st_ff.prev[0];
    e_off = btn_off & ~st_ff.prev[1];
    e_up = btn_up & ~st_ff.prev[2];
    e_down = btn_down & ~st_ff.prev[3];
    e_rrun = remote_run & ~st_ff.prev[4];
    f_rrun = ~remote_run & st_ff.prev[4];
    e_rrst = remote_reset & ~st_ff.prev[5];
    nxt_st.prev = {remote_reset, remote_run, btn_down, btn_up, btn_off, btn_on};

    // Bus handshake: a request is answered one cycle after it is taken.
    nxt_st.wait_n = 1'b0;
    if ((avs_read || avs_write) && !st_ff.wait_n) begin
      nxt_st.wait_n = 1'b1;
      nxt_st.rdata = 32'h0;
      if (avs_write && avs_address == `CSC_OFS_CMD) begin
        ser_on = avs_writedata[`CSC_CMD_ON_BIT];
        ser_off = avs_writedata[`CSC_CMD_OFF_BIT];
      end
      if (avs_read) begin
        sts = {14'h0, st_ff.disp_line, st_ff.top_line, st_ff.restart_pend, st_ff.retry_wait,
               st_ff.retry_cnt, st_ff.alarm, st_ff.shutdown, st_ff.mode2, st_ff.ch_only, st_ff.run};
        case (avs_address)
          `CSC_OFS_STATUS: nxt_st.rdata = sts;
          `CSC_OFS_POINTS: nxt_st.rdata = {16'h0, st_ff.pts};
          default: nxt_st.rdata = 32'h0;
        endcase
      end
    end

    // Mode two shuts out the panel and the serial commands.
    if (st_ff.mode2) begin
      e_on = 1'b0;
      e_off = 1'b0;
      ser_on = 1'b0;
      ser_off = 1'b0;
    end

    // Error clearing: remote pulse always (except the guarded window), both arrows in mode one.
    if (e_rrst && !(st_ff.mode2 && st_ff.retry_wait
                    && st_ff.retry_sec < 12'(`CSC_RST_IGNORE_T))) begin
      clr = 1'b1;
    end
    if (btn_up && btn_down && (e_up || e_down) && !st_ff.mode2) begin
      clr = 1'b1;
    end
    if (clr) begin
      nxt_st.pts = 16'h0;
      nxt_st.retry_cnt = 3'h0;
      nxt_st.retry_wait = 1'b0;
      nxt_st.top_line = `CSC_LINE_ELAPSED;
    end

    // Automatic retry interval after a helium overheat shutdown.
    if (st_ff.retry_wait && tick) begin
      nxt_st.retry_sec = 12'(st_ff.retry_sec + 12'h1);
      if (st_ff.retry_sec == 12'(`CSC_RETRY_T - 1)) begin
        nxt_st.retry_wait = 1'b0;
        nxt_st.retry_cnt = 3'(st_ff.retry_cnt + 3'h1);
        nxt_st.pts[1:0] = CSC_PT_OK;
        if (!st_ff.mode2) begin
          nxt_st.run = 1'b1;
        end
      end
    end

    // Status latching after any clear, so a fault present now is never lost.
    // Faults wait for the captured mode, or the cable compare would trip on the reset value.
    for (int i = 0; i < 8; i++) begin
      if (sensor_open[i]) begin
        nxt_st.pts[2*i +: 2] = CSC_PT_FAIL;
      end else if (st_ff.init && fault[i] && nxt_st.pts[2*i +: 2] == CSC_PT_OK) begin
        nxt_st.pts[2*i +: 2] = CSC_PT_ERR;
        newerr[i] = 1'b1;
      end
      err[i] = nxt_st.pts[2*i +: 2] != CSC_PT_OK;
    end

    // A fresh failure jumps to the top; older ones remain reachable by scrolling.
    if (|newerr) begin
      nxt_st.top_line = csc_top_of(newerr);
      nxt_st.disp_line = csc_top_of(newerr);
      nxt_st.disp_act = 1'b0;
    end

    // A fresh helium overheat arms a retry unless the retry budget is spent.
    if (newerr[0] && nxt_st.retry_cnt < `CSC_RETRY_MAX) begin
      nxt_st.retry_wait = 1'b1;
      nxt_st.retry_sec = 12'h0;
    end

    // Classify the latched errors.
    sd_now = err & `CSC_SD_MASK;
    nxt_st.shutdown = |sd_now;
    nxt_st.alarm = |(err & `CSC_AL_MASK);

    // Outage restart after a short delay.
    if (st_ff.restart_pend && tick) begin
      nxt_st.restart_sec = 8'(st_ff.restart_sec + 8'h1);
      if (st_ff.restart_sec == 8'(`CSC_RESTART_DLY_T - 1)) begin
        nxt_st.restart_pend = 1'b0;
        nxt_st.run = 1'b1;
      end
    end

    // Panel and serial commands (already masked in mode two).
    if (e_on || ser_on) begin
      if (!st_ff.run && !st_ff.ch_only && st_ff.disp_line == `CSC_LINE_CH_RUN && e_on) begin
        nxt_st.ch_only = 1'b1;
        nxt_st.ch_sec = 12'h0;
      end else begin
        nxt_st.run = 1'b1;
      end
    end
    if (e_off || ser_off) begin
      nxt_st.run = 1'b0;
      nxt_st.ch_only = 1'b0;
      nxt_st.restart_pend = 1'b0;
    end

    // Remote run line: edges in mode one win over the rest, level in mode two.
    if (st_ff.mode2) begin
      nxt_st.run = remote_run;
    end else if (e_rrun) begin
      nxt_st.run = 1'b1;
    end else if (f_rrun) begin
      nxt_st.run = 1'b0;
    end

    // Cold head maintenance run times out.
    if (st_ff.ch_only && tick) begin
      nxt_st.ch_sec = 12'(st_ff.ch_sec + 12'h1);
      if (st_ff.ch_sec == 12'(`CSC_CH_LIMIT_T - 1)) begin
        nxt_st.ch_only = 1'b0;
      end
    end
    if (nxt_st.run) begin
      nxt_st.ch_only = 1'b0;
    end

    // Any shutdown-class error stops both motors and holds them off.
    if (nxt_st.shutdown) begin
      nxt_st.run = 1'b0;
      nxt_st.ch_only = 1'b0;
      nxt_st.restart_pend = 1'b0;
    end
    off_now = !nxt_st.run && !nxt_st.ch_only;

    // Display scrolling with wrap, unless both arrows together mean clear.
    if ((e_up ^ e_down) && !(btn_up && btn_down)) begin
      nxt_st.disp_line = csc_step(st_ff.disp_line, e_up, off_now);
      nxt_st.disp_act = 1'b1;
      nxt_st.disp_sec = 6'h0;
    end else if (st_ff.disp_act && tick) begin
      nxt_st.disp_sec = 6'(st_ff.disp_sec + 6'h1);
      if (st_ff.disp_sec == 6'(`CSC_DISP_TIMEOUT_T - 1)) begin
        nxt_st.disp_act = 1'b0;
        nxt_st.disp_line = nxt_st.top_line;
      end
    end
    // The cold head line disappears once anything runs.
    if (!off_now && nxt_st.disp_line == `CSC_LINE_CH_RUN) begin
      nxt_st.disp_line = `CSC_LINE_ELAPSED;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flip-flop bank.

  // Reset loads constants only; the strap is caught in the first clocked cycle.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
      st_ff.disp_line <= `CSC_RST_LINE;
      st_ff.top_line <= `CSC_RST_LINE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, straight from the state flip-flops.

  // Motors follow the run state; the cold head also runs alone for maintenance.
  assign comp_motor = st_ff.run;
  assign cold_head = st_ff.run | st_ff.ch_only;

  // Remote connector reports latched errors and their classes.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      point_err[i] = st_ff.pts[2*i +: 2] != CSC_PT_OK;
    end
  end
  assign shutdown_out = st_ff.shutdown;
  assign alarm_out = st_ff.alarm;

  // Display selection and every point's status word.
  assign disp_line = st_ff.disp_line;
  assign disp_status = st_ff.pts;

  // Bus answer.
  assign avs_readdata = st_ff.rdata;
  assign avs_waitrequest = ~st_ff.wait_n;

endmodule
`default_nettype wire

// ==== logic/csc_pkg.sv ====
// Types of the compressor supervisory controller.
// Assumes csc_cfg.svh sits beside it on the include path.
`default_nettype none
package csc_pkg;
  `include "csc_cfg.svh"

  // Per-point display status.
  typedef enum logic [1:0] {
    CSC_PT_OK = 2'b00,
    CSC_PT_ERR = 2'b01,
    CSC_PT_FAIL = 2'b10
  } csc_pt_t;

  // Whole state of the controller, registered in one flip-flop bank.
  typedef struct packed {
    logic init;          // Strap and outage sampled.
    logic mode2;         // Configuration mode two captured at start.
    logic run;           // Compressor motor and cold head running.
    logic ch_only;       // Cold head maintenance run.
    logic [31:0] pre;    // Prescaler for the one-second tick.
    logic [11:0] ch_sec; // Cold head run seconds.
    logic disp_act;      // Display timeout armed.
    logic [5:0] disp_sec;
    logic [3:0] disp_line;
    logic [3:0] top_line;
    logic retry_wait;    // Waiting out an automatic retry interval.
    logic [11:0] retry_sec;
    logic [2:0] retry_cnt;
    logic restart_pend;  // Outage restart delay running.
    logic [7:0] restart_sec;
    logic [15:0] pts;    // Two status bits per point.
    logic [5:0] prev;    // Previous input levels for edge detection.
    logic shutdown;
    logic alarm;
    logic wait_n;        // Inverted waitrequest.
    logic [31:0] rdata;
  } csc_state_t;
endpackage
`default_nettype wire

// ==== test/csc_ctrl_assertions.sv ====
// Concurrent checks on the supervisory controller's ports.
// Assumes one clock domain and a configuration strap held steady between resets.
`timescale 1ns/1ns
`default_nettype none
module csc_ctrl_assertions (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Bus handshake.
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Commands and strap.
  input wire logic btn_on,
  input wire logic btn_off,
  input wire logic cfg_mode2,
  input wire logic remote_run,
  input wire logic cable_mode2,
  // Monitored points.
  input wire logic [7:0] he_temp_c,
  input wire logic [7:0] water_temp_c,
  input wire logic [7:0] ret_press_psig,
  input wire logic [7:0] sensor_open,
  // Outputs under check.
  input wire logic comp_motor,
  input wire logic cold_head,
  input wire logic [7:0] point_err,
  input wire logic shutdown_out,
  input wire logic alarm_out,
  input wire logic [3:0] disp_line,
  input wire logic [15:0] disp_status
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////
  // A clean panel start: mode one, no shutdown, remote line quiet.
  sequence s_on1;
    !cfg_mode2 && $rose(btn_on) && !btn_off && $stable(remote_run) && !shutdown_out && disp_line != 4'hb;
  endsequence
  // A stop press with no competing start.
  sequence s_off1;
    !cfg_mode2 && $rose(btn_off) && !$rose(btn_on) && $stable(remote_run);
  endsequence
  ////////////////////////////////////////////////////////////////////////
  AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not a single cycle");
  AST_ON_START: assert property (s_on1 |=> comp_motor && cold_head)
    else $error("panel start ignored");
  AST_OFF_STOP: assert property (s_off1 |=> !comp_motor && !cold_head)
    else $error("panel stop ignored");
  AST_MODE2_IGNORE: assert property (cfg_mode2 && !remote_run && !comp_motor && $rose(btn_on) |=> !comp_motor)
    else $error("panel start obeyed in mode two");
  AST_HE_SD: assert property (he_temp_c > 8'h5d |-> ##[1:2] (shutdown_out && point_err[0]))
    else $error("helium overheat not latched");
  AST_SD_STOP: assert property ($rose(shutdown_out) |-> ##[0:1] (!comp_motor && !cold_head))
    else $error("shutdown left a motor running");
  AST_WATER_AL: assert property (water_temp_c > 8'h23 |-> ##[1:2] (alarm_out && point_err[1]))
    else $error("water alarm not latched");
  AST_ALARM_RUNS: assert property ($rose(alarm_out) && comp_motor && !shutdown_out |=> comp_motor)
    else $error("alarm stopped the compressor");
  AST_PRESS_SD: assert property (ret_press_psig < 8'h0f |-> ##[1:2] (shutdown_out && point_err[5]))
    else $error("low return pressure not latched");
  AST_CABLE_SD: assert property (cable_mode2 != cfg_mode2 |-> ##[1:2] (shutdown_out && point_err[7]))
    else $error("cable mismatch not latched");
  AST_FAIL: assert property (sensor_open[2] |-> ##[1:2] (disp_status[5:4] == 2'b10))
    else $error("open sensor not shown as fail");
endmodule
bind csc_ctrl csc_ctrl_assertions u_chk (.clk, .rstn, .avs_read, .avs_write, .avs_waitrequest, .btn_on, .btn_off,
  .cfg_mode2, .remote_run, .cable_mode2, .he_temp_c, .water_temp_c, .ret_press_psig, .sensor_open, .comp_motor,
  .cold_head, .point_err, .shutdown_out, .alarm_out, .disp_line, .disp_status);
`default_nettype wire

// ==== test/csc_partner.sv ====
// Remote host on the diagnostic connector: run level and momentary reset.
// Assumes the bench issues one-cycle command codes synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module csc_partner (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Bench command: 1 run, 2 stop, 3 reset pulse.
  input wire logic [1:0] cmd,
  // Connector lines.
  output logic remote_run,
  output logic remote_reset
);
  logic [1:0] pulse_ff; // Reset pulse cycles left.
  // The run line is a level held until the host drops it; the reset is momentary.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      remote_run <= 1'b0;
      pulse_ff <= 2'h0;
    end else begin
      if (cmd == 2'h1) remote_run <= 1'b1;
      if (cmd == 2'h2) remote_run <= 1'b0;
      if (cmd == 2'h3) pulse_ff <= 2'h3;
      else if (pulse_ff != 2'h0) pulse_ff <= pulse_ff - 2'h1;
    end
  end
  assign remote_reset = (pulse_ff != 2'h0);
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench of the supervisory controller with a remote host model.
// Assumes a shortened tick so the long intervals fit in a short run.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk, rstn, rd_s, wr_s, cfg, outage, cable, wreq, cm, ch, sd, al, rr, rrst, hang;
  logic [3:0] adr, b, dl;
  logic [31:0] wd, rdat, seed, r, me, mm;
  logic [7:0] he, wt, fl, rp, so, pe;
  logic [15:0] ds;
  logic [1:0] pc;
  logic [31:0] q_exp[$], q_msk[$]; // Expected read words and masks.
  int n_mismatch, cmp_count, k;
  csc_ctrl #(.TICK_CYCLES(4)) dut (.clk(clk), .rstn(rstn), .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s),
    .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wreq), .btn_on(b[0]), .btn_off(b[1]), .btn_up(b[2]),
    .btn_down(b[3]), .cfg_mode2(cfg), .last_stop_outage(outage), .remote_run(rr), .remote_reset(rrst),
    .cable_mode2(cable), .he_temp_c(he), .water_temp_c(wt), .flow_temp_c(fl), .ret_press_psig(rp),
    .motor_trip(1'b0), .phase_fault(1'b0), .sensor_open(so), .comp_motor(cm), .cold_head(ch), .point_err(pe),
    .shutdown_out(sd), .alarm_out(al), .disp_line(dl), .disp_status(ds));
  csc_partner u_host (.clk(clk), .rstn(rstn), .cmd(pc), .remote_run(rr), .remote_reset(rrst));
  ////////////////////////////////////////////////////////////////////////
  // Free-running 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Compare one value and count the outcome.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One Avalon access, held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    rd_s <= !w;
    wr_s <= w;
    adr <= a;
    wd <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (wreq === 1'b0) break;
    end
    if (i == 20) begin
      n_mismatch++;
      hang <= 1'b1;
    end
    rd_s <= 1'b0;
    wr_s <= 1'b0;
  endtask
  // A read notes its expectation; the monitor judges the answer.
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    q_exp.push_back(e);
    q_msk.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask
  // Press a set of panel buttons briefly.
  task automatic push(input logic [3:0] m);
    b <= m;
    cyc(2);
    b <= 4'h0;
    cyc(3);
  endtask
  task automatic host(input logic [1:0] c);
    pc <= c;
    cyc(1);
    pc <= 2'h0;
    cyc(5);
  endtask
  // Reset with a given strap, power history and cable; helium starts at a random safe value.
  task automatic start(input logic c, input logic o, input logic k2);
    r = $random(seed);
    cfg <= c;
    outage <= o;
    cable <= k2;
    he <= 8'h14 + {2'h0, r[5:0]};
    rstn <= 1'b0;
    cyc(10);
    rstn <= 1'b1;
    cyc(3);
  endtask
  task automatic wrap_up();
    $display("Mismatches %0d of %0d comparisons", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Monitor: each read answer is matched to the oldest note.
  always @(posedge clk) begin
    if (rd_s && wreq === 1'b0 && q_exp.size() > 0) begin
      me = q_exp.pop_front();
      mm = q_msk.pop_front();
      chk("readdata", rdat & mm, me);
    end
  end
  // A stuck handshake ends the run.
  initial begin
    wait (hang === 1'b1);
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, rd_s, wr_s, cfg, outage, cable, hang} = 7'h0;
    {adr, b, wd, pc} = 42'h0;
    {wt, fl, rp, so} = {8'h14, 8'h14, 8'h64, 8'h00};
    he = 8'h14;
    seed = 32'hacba4c72;
    start(1'b0, 1'b0, 1'b0);
    rd(4'h4, 32'h0, 32'hffffffff);
    rd(4'hc, 32'h0, 32'hffffffff);
    cyc(40);
    chk("comp_motor", 32'(cm), 32'h0);
    push(4'h1);
    chk("run", 32'({ch, cm}), 32'h3);
    push(4'h2);
    chk("run", 32'({ch, cm}), 32'h0);
    bus(1'b1, 4'h0, 32'h1);
    rd(4'h4, 32'h1, 32'h3ff);
    bus(1'b1, 4'h0, 32'h2);
    chk("run", 32'({ch, cm}), 32'h0);
    host(2'h1);
    chk("run", 32'({ch, cm}), 32'h3);
    host(2'h2);
    chk("run", 32'({ch, cm}), 32'h0);
    $display("Test run control done");
    push(4'h1);
    wt <= 8'h23;
    cyc(4);
    chk("alarm_out", 32'(al), 32'h0);
    wt <= 8'h24;
    cyc(4);
    chk("alarm_out", 32'(al), 32'h1);
    chk("comp_motor", 32'(cm), 32'h1);
    chk("disp_line", 32'(dl), 32'h2);
    he <= 8'h5e;
    cyc(4);
    chk("run", 32'({ch, cm}), 32'h0);
    chk("disp_line", 32'(dl), 32'h1);
    chk("point_err", 32'(pe), 32'h3);
    push(4'h1);
    chk("comp_motor", 32'(cm), 32'h0);
    he <= 8'h14;
    wt <= 8'h14;
    push(4'hc);
    chk("point_err", 32'(pe), 32'h0);
    $display("Test faults done");
    he <= 8'h5e;
    cyc(26000);
    rd(4'h4, 32'ha8, 32'h3ff);
    he <= 8'h14;
    host(2'h3);
    rd(4'h4, 32'h0, 32'h3ff);
    so <= 8'h04;
    cyc(4);
    chk("fail", 32'(ds[5:4]), 32'h2);
    so <= 8'h00;
    push(4'hc);
    chk("point_err", 32'(pe), 32'h0);
    $display("Test retry done");
    for (k = 0; k < 12 && dl !== 4'hb; k++) push(4'h8);
    chk("disp_line", 32'(dl), 32'hb);
    push(4'h1);
    chk("run", 32'({ch, cm}), 32'h2);
    push(4'h8);
    chk("disp_line", 32'(dl), 32'h1);
    cyc(200);
    chk("disp_line", 32'(dl), 32'h0);
    cyc(7200);
    chk("cold_head", 32'(ch), 32'h0);
    $display("Test cold head done");
    start(1'b1, 1'b0, 1'b1);
    push(4'h1);
    bus(1'b1, 4'h0, 32'h1);
    chk("comp_motor", 32'(cm), 32'h0);
    host(2'h1);
    chk("run", 32'({ch, cm}), 32'h3);
    host(2'h2);
    rp <= 8'h0a;
    cyc(4);
    chk("point_err", 32'(pe), 32'h20);
    chk("shutdown_out", 32'(sd), 32'h1);
    rp <= 8'h64;
    push(4'hc);
    chk("point_err", 32'(pe), 32'h20);
    host(2'h3);
    chk("point_err", 32'(pe), 32'h0);
    cable <= 1'b0;
    cyc(4);
    chk("cable", 32'(pe[7]), 32'h1);
    $display("Test mode two done");
    start(1'b0, 1'b1, 1'b0);
    cyc(60);
    chk("run", 32'({ch, cm}), 32'h3);
    $display("Test outage done");
    wrap_up();
  end
endmodule
`default_nettype wire
